// file: hw/dtm_defines.vh
`ifndef DTM_DEFINES_VH
`define DTM_DEFINES_VH

// ----------------------------------------------------------------
// command codes {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------------------------------
`define DTM_CMD_MODE_SET 4'h0
`define DTM_CMD_READ 4'h5

// ----------------------------------------------------------------
// mode register selection on the bank address
// ----------------------------------------------------------------
`define DTM_MR_ZERO 3'h0
`define DTM_MR_ONE 3'h1
`define DTM_MR_THREE 3'h3

// ----------------------------------------------------------------
// address bit positions
// ----------------------------------------------------------------
`define DTM_MR0_BL_HI 1
`define DTM_MR0_BL_LO 0
`define DTM_MR1_LEVEL_BIT 7
`define DTM_MR1_QOFF_BIT 12
`define DTM_MR3_PAT_BIT 2
`define DTM_MR3_LOC_HI 1
`define DTM_MR3_LOC_LO 0
`define DTM_A_AUTOCLOSE 10
`define DTM_A_CHOP 12
`define DTM_A_NIBBLE 2
`define DTM_COL_HI 9

// ----------------------------------------------------------------
// burst length modes and beat counts
// ----------------------------------------------------------------
`define DTM_BL_FIXED8 2'h0
`define DTM_BL_OTF 2'h1
`define DTM_BL_FIXED4 2'h2
`define DTM_BEATS_BL8 4'h8
`define DTM_BEATS_BC4 4'h4

// ----------------------------------------------------------------
// pattern locations and contents
// ----------------------------------------------------------------
`define DTM_LOC_CAL 2'h0
`define DTM_CAL_PATTERN 8'hAA
`define DTM_RSV_PATTERN 8'h00

// ----------------------------------------------------------------
// register map and layouts
// ----------------------------------------------------------------
`define DTM_ADR_CTRL 8'h00
`define DTM_ADR_LAT 8'h04
`define DTM_ADR_STAT 8'h08
`define DTM_CTRL_RESET 32'h00000001
`define DTM_LAT_RESET 32'h00000600
`define DTM_CTRL_COPY 0
`define DTM_CTRL_PRIME 1
`define DTM_LAT_AL_HI 4
`define DTM_LAT_AL_LO 0
`define DTM_LAT_CL_HI 12
`define DTM_LAT_CL_LO 8

`endif

// file: hw/dtm_sync.v
`timescale 1ns/10ps
module dtm_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule

// file: hw/dtm_burst.v
`timescale 1ns/10ps
`include "dtm_defines.vh"
module dtm_burst (
  input wire clk_i,
  input wire rst_i,
  input wire start_i,
  input wire chop_i,
  input wire nibble_i,
  input wire [5:0] rl_i,
  input wire [7:0] pat_i,
  input wire ck_rise_i,
  input wire ck_fall_i,
  output reg bit_o,
  output reg strobe_o,
  output reg drive_o,
  output wire busy_o
);
  localparam S_IDLE = 3'b001;
  localparam S_WAIT = 3'b010;
  localparam S_DATA = 3'b100;

  reg [2:0] state_reg;
  reg [5:0] cnt_reg;
  reg [3:0] beat_reg;
  reg chop_reg;
  reg nib_reg;
  reg [7:0] pat_reg;
  wire [3:0] nbeats;
  wire [2:0] order;

  assign nbeats = chop_reg ? `DTM_BEATS_BC4 : `DTM_BEATS_BL8;
  // burst order index, upper nibble when chopped with the nibble bit set
  assign order = {beat_reg[2] | nib_reg, beat_reg[1:0]};
  assign busy_o = (state_reg != S_IDLE);

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      cnt_reg <= 6'h00;
      beat_reg <= 4'h0;
      chop_reg <= 1'b0;
      nib_reg <= 1'b0;
      pat_reg <= 8'h00;
      bit_o <= 1'b0;
      strobe_o <= 1'b0;
      drive_o <= 1'b0;
    end else if (start_i) begin
      state_reg <= S_WAIT;
      cnt_reg <= (rl_i == 6'h00) ? 6'h01 : rl_i;
      beat_reg <= 4'h0;
      chop_reg <= chop_i;
      nib_reg <= nibble_i & chop_i;
      pat_reg <= pat_i;
      // a restart cuts any burst in flight, so the pins go quiet during the wait
      bit_o <= 1'b0;
      strobe_o <= 1'b0;
      drive_o <= 1'b0;
    end else begin
      case (state_reg)
        S_WAIT: begin
          if (ck_rise_i) begin
            cnt_reg <= cnt_reg - 6'h01;
            if (cnt_reg == 6'h01) begin
              state_reg <= S_DATA;
              bit_o <= pat_reg[order];
              beat_reg <= beat_reg + 4'h1;
              strobe_o <= 1'b1;
              drive_o <= 1'b1;
            end
          end
        end
        S_DATA: begin
          if (ck_rise_i | ck_fall_i) begin
            if (beat_reg == nbeats) begin
              state_reg <= S_IDLE;
              drive_o <= 1'b0;
              strobe_o <= 1'b0;
              bit_o <= 1'b0;
            end else begin
              bit_o <= pat_reg[order];
              beat_reg <= beat_reg + 4'h1;
              strobe_o <= ~strobe_o;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// file: hw/dtm_top.v
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "dtm_defines.vh"
module dtm_top (
  input wire clk_i,
  input wire rst_i,
  input wire ck_i,
  input wire reset_n_i,
  input wire cs_n_i,
  input wire ras_n_i,
  input wire cas_n_i,
  input wire we_n_i,
  input wire [2:0] ba_i,
  input wire [12:0] addr_i,
  input wire odt_i,
  input wire [1:0] dqs_i,
  output reg [15:0] dq_o,
  output reg [15:0] dq_oe_n_o,
  output reg [1:0] dqs_o,
  output reg [1:0] dqs_oe_n_o,
  output reg rtt_dqs_o,
  output reg rtt_dq_o,
  output reg array_rd_o,
  output reg [9:0] array_col_o,
  output reg [2:0] array_ba_o,
  output reg auto_pre_o,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o
);
  // ----------------------------------------------------------------
  // pin synchronisers and clock edge detection
  // ----------------------------------------------------------------
  localparam SW = 25;
  wire [SW-1:0] s_pins;
  wire s_ck;
  wire s_reset_n;
  wire [3:0] s_cmd;
  wire [2:0] s_ba;
  wire [12:0] s_a;
  wire s_odt;
  wire [1:0] s_dqs;

  dtm_sync #(.W(SW)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({ck_i, reset_n_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i, odt_i, dqs_i}),
    .q_o(s_pins)
  );
  assign {s_ck, s_reset_n, s_cmd, s_ba, s_a, s_odt, s_dqs} = s_pins;

  reg ck_d_reg;
  reg [1:0] dqs_d_reg;
  wire ck_rise;
  wire ck_fall;
  wire [1:0] dqs_rise;
  wire dram_rst;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ck_d_reg <= 1'b0;
      dqs_d_reg <= 2'b00;
    end else begin
      ck_d_reg <= s_ck;
      dqs_d_reg <= s_dqs;
    end
  end
  assign ck_rise = s_ck & ~ck_d_reg;
  assign ck_fall = ~s_ck & ck_d_reg;
  assign dqs_rise = s_dqs & ~dqs_d_reg;
  assign dram_rst = rst_i | ~s_reset_n;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  reg [31:0] ctrl_reg;
  reg [31:0] lat_reg;
  wire [31:0] sel_mask;
  wire wb_req;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ----------------------------------------------------------------
  // mode state
  // ----------------------------------------------------------------
  reg [1:0] bl_mode_reg;
  reg level_reg;
  reg qoff_reg;
  reg pat_en_reg;
  reg [1:0] loc_reg;
  reg [1:0] fb_reg;
  reg [1:0] fb_seen_reg;
  reg rd_start_reg;
  reg rd_chop_reg;
  reg rd_nib_reg;
  reg [7:0] rd_pat_reg;
  wire is_mode_set;
  wire is_read;
  wire chop_now;
  wire [5:0] rl;
  wire b_bit;
  wire b_strobe;
  wire b_drive;
  wire b_busy;
  wire [31:0] stat_word;

  assign is_mode_set = ck_rise & (s_cmd == `DTM_CMD_MODE_SET);
  assign is_read = ck_rise & (s_cmd == `DTM_CMD_READ);
  assign chop_now = (bl_mode_reg == `DTM_BL_FIXED4) |
                    ((bl_mode_reg == `DTM_BL_OTF) & ~s_a[`DTM_A_CHOP]);
  assign rl = {1'b0, lat_reg[`DTM_LAT_AL_HI:`DTM_LAT_AL_LO]} +
              {1'b0, lat_reg[`DTM_LAT_CL_HI:`DTM_LAT_CL_LO]};
  assign stat_word = {22'h000000, b_busy, fb_reg, qoff_reg, loc_reg, pat_en_reg, level_reg, bl_mode_reg};

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `DTM_CTRL_RESET;
      lat_reg <= `DTM_LAT_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req) begin
        if (wb_adr_i == `DTM_ADR_CTRL) begin
          if (wb_we_i) begin
            ctrl_reg <= (ctrl_reg & ~sel_mask) | (wb_dat_i & sel_mask);
          end
          wb_dat_o <= ctrl_reg;
        end else if (wb_adr_i == `DTM_ADR_LAT) begin
          if (wb_we_i) begin
            lat_reg <= (lat_reg & ~sel_mask) | (wb_dat_i & sel_mask);
          end
          wb_dat_o <= lat_reg;
        end else if (wb_adr_i == `DTM_ADR_STAT) begin
          wb_dat_o <= stat_word;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (dram_rst) begin
      bl_mode_reg <= `DTM_BL_FIXED8;
      level_reg <= 1'b0;
      qoff_reg <= 1'b0;
      pat_en_reg <= 1'b0;
      loc_reg <= `DTM_LOC_CAL;
      rd_start_reg <= 1'b0;
      rd_chop_reg <= 1'b0;
      rd_nib_reg <= 1'b0;
      rd_pat_reg <= 8'h00;
      array_rd_o <= 1'b0;
      array_col_o <= 10'h000;
      array_ba_o <= 3'h0;
      auto_pre_o <= 1'b0;
    end else begin
      rd_start_reg <= 1'b0;
      array_rd_o <= 1'b0;
      auto_pre_o <= 1'b0;
      if (is_mode_set) begin
        if (s_ba == `DTM_MR_ZERO) begin
          bl_mode_reg <= s_a[`DTM_MR0_BL_HI:`DTM_MR0_BL_LO];
        end else if (s_ba == `DTM_MR_ONE) begin
          level_reg <= s_a[`DTM_MR1_LEVEL_BIT];
          qoff_reg <= s_a[`DTM_MR1_QOFF_BIT];
        end else if (s_ba == `DTM_MR_THREE) begin
          pat_en_reg <= s_a[`DTM_MR3_PAT_BIT];
          loc_reg <= s_a[`DTM_MR3_LOC_HI:`DTM_MR3_LOC_LO];
        end
      end else if (is_read) begin
        if (pat_en_reg) begin
          // bank and column bits beyond the nibble select are not looked at
          rd_start_reg <= 1'b1;
          rd_chop_reg <= chop_now;
          rd_nib_reg <= chop_now & s_a[`DTM_A_NIBBLE];
          rd_pat_reg <= (loc_reg == `DTM_LOC_CAL) ? `DTM_CAL_PATTERN : `DTM_RSV_PATTERN;
        end else begin
          array_rd_o <= 1'b1;
          array_col_o <= s_a[`DTM_COL_HI:0];
          array_ba_o <= s_ba;
          auto_pre_o <= s_a[`DTM_A_AUTOCLOSE];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pattern burst sequencer
  // ----------------------------------------------------------------
  dtm_burst u_burst (
    .clk_i(clk_i),
    .rst_i(dram_rst),
    .start_i(rd_start_reg),
    .chop_i(rd_chop_reg),
    .nibble_i(rd_nib_reg),
    .rl_i(rl),
    .pat_i(rd_pat_reg),
    .ck_rise_i(ck_rise),
    .ck_fall_i(ck_fall),
    .bit_o(b_bit),
    .strobe_o(b_strobe),
    .drive_o(b_drive),
    .busy_o(b_busy)
  );

  // ----------------------------------------------------------------
  // per-lane leveling feedback and data pin drive
  // ----------------------------------------------------------------
  genvar ln;
  generate
    for (ln = 0; ln < 2; ln = ln + 1) begin : g_lane
      always @(posedge clk_i) begin
        if (dram_rst) begin
          fb_reg[ln] <= 1'b0;
          fb_seen_reg[ln] <= 1'b0;
          dq_o[ln*8+7:ln*8] <= 8'h00;
          dq_oe_n_o[ln*8+7:ln*8] <= 8'hFF;
          dqs_o[ln] <= 1'b0;
          dqs_oe_n_o[ln] <= 1'b1;
        end else begin
          if (~level_reg) begin
            fb_seen_reg[ln] <= 1'b0;
          end else if (dqs_rise[ln]) begin
            fb_reg[ln] <= s_ck;
            fb_seen_reg[ln] <= 1'b1;
          end
          if (level_reg & ~qoff_reg) begin
            dq_oe_n_o[ln*8+7:ln*8] <= 8'h00;
            dqs_oe_n_o[ln] <= 1'b1;
            dq_o[ln*8] <= fb_reg[ln] & fb_seen_reg[ln];
            dq_o[ln*8+7:ln*8+1] <= ctrl_reg[`DTM_CTRL_PRIME] ? 7'h00 :
                                   {7{fb_reg[ln] & fb_seen_reg[ln]}};
          end else if (b_drive) begin
            dq_oe_n_o[ln*8+7:ln*8] <= 8'h00;
            dqs_oe_n_o[ln] <= 1'b0;
            dqs_o[ln] <= b_strobe;
            dq_o[ln*8] <= b_bit;
            dq_o[ln*8+7:ln*8+1] <= ctrl_reg[`DTM_CTRL_COPY] ? {7{b_bit}} : 7'h00;
          end else begin
            dq_oe_n_o[ln*8+7:ln*8] <= 8'hFF;
            dqs_oe_n_o[ln] <= 1'b1;
            dqs_o[ln] <= 1'b0;
            dq_o[ln*8+7:ln*8] <= 8'h00;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // termination control
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (dram_rst) begin
      rtt_dqs_o <= 1'b0;
      rtt_dq_o <= 1'b0;
    end else if (level_reg) begin
      rtt_dqs_o <= s_odt;
      rtt_dq_o <= 1'b0;
    end else begin
      rtt_dqs_o <= s_odt;
      rtt_dq_o <= s_odt;
    end
  end
endmodule

// file: sim/dtm_props.sv
`timescale 1ns/10ps
module dtm_props (
  input wire clk_i,
  input wire rst_i,
  input wire reset_n_i,
  input wire [15:0] dq_o,
  input wire [15:0] dq_oe_n_o,
  input wire [1:0] dqs_o,
  input wire [1:0] dqs_oe_n_o,
  input wire rtt_dqs_o,
  input wire rtt_dq_o,
  input wire array_rd_o,
  input wire auto_pre_o
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  byte_copy_a: assert property (!dq_oe_n_o[0] |-> dq_o[7:1] == 7'h00 || dq_o[7:1] == {7{dq_o[0]}})
    else $error("low byte bits neither copy nor zero");
  lane_hi_a: assert property (!dq_oe_n_o[8] |-> dq_o[15:9] == 7'h00 || dq_o[15:9] == {7{dq_o[8]}})
    else $error("high byte bits neither copy nor zero");
  dq_term_a: assert property (rtt_dq_o |-> rtt_dqs_o)
    else $error("data termination without strobe termination");
  pat_no_array_a: assert property (!dqs_oe_n_o[0] |-> !array_rd_o)
    else $error("array read during pattern burst");
  autoclose_a: assert property (auto_pre_o |-> array_rd_o)
    else $error("precharge without array read");
  rd_pulse_a: assert property (array_rd_o |=> !array_rd_o)
    else $error("array read longer than one cycle");
  pin_reset_a: assert property (!reset_n_i [*6] |-> dq_oe_n_o == 16'hFFFF && dqs_oe_n_o == 2'h3)
    else $error("pins driven while reset pin low");
  first_beat_a: assert property ($fell(dqs_oe_n_o[0]) |-> dqs_o[0])
    else $error("burst strobe did not start high");
  burst_len_a: assert property ($fell(dqs_oe_n_o[0]) |-> ##14 !dqs_oe_n_o[0] ##[1:22] dqs_oe_n_o[0])
    else $error("burst length out of range");
  cover property ($fell(dqs_oe_n_o[0]));
  cover property (array_rd_o && auto_pre_o);
  cover property (!dq_oe_n_o[0] && dqs_oe_n_o[0]);
endmodule

// file: sim/dtm_ctrl_model.sv
`timescale 1ns/10ps
`include "dtm_defines.vh"
module dtm_ctrl_model #(
  parameter MOD_GAP = 12
) (
  input wire clk_i,
  input wire [15:0] dq_i,
  input wire [1:0] dqs_i,
  input wire [1:0] dqs_oe_n_i,
  output reg ck_o,
  output reg cs_n_o,
  output reg ras_n_o,
  output reg cas_n_o,
  output reg we_n_o,
  output reg [2:0] ba_o,
  output reg [12:0] addr_o,
  output reg odt_o,
  output reg [1:0] dqs_o
);
  integer rises = 0;
  integer base = 0;
  integer rl_seen = 0;
  reg prev_oe = 1'b1;
  reg prev_dqs = 1'b0;
  reg [15:0] beats [$];
  // ----------------------------------------
  // free running clock, commands, strobes
  // ----------------------------------------
  // delay lock loop taken as locked from the start
  initial begin
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
    ba_o = 3'h0;
    addr_o = 13'h0000;
    odt_o = 1'b0;
    dqs_o = 2'h0;
    ck_o = 1'b0;
    #3;
    forever #40 ck_o = ~ck_o;
  end
  always @(posedge ck_o) rises = rises + 1;
  task cmd(input [3:0] code, input [2:0] ba, input [12:0] a);
    begin
      @(negedge ck_o);
      @(posedge clk_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= code;
      ba_o <= ba;
      addr_o <= a;
      @(posedge ck_o);
      #1 base = rises;
      @(negedge ck_o);
      @(posedge clk_i);
      // deselected pins never keep the last value
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= {1'b1, ~code[2:0]};
      ba_o <= ~ba;
      addr_o <= ~a;
    end
  endtask
  // no row is ever opened, so banks stay idle and precharged
  task mode_set_command(input [2:0] ba, input [12:0] a);
    begin
      cmd(`DTM_CMD_MODE_SET, ba, a);
      repeat (MOD_GAP) @(posedge ck_o);
    end
  endtask
  // one strobe pulse as long as a clock phase, rising inside the chosen phase, strobe parked low after
  task lvl(input level);
    begin
      if (level) @(posedge ck_o);
      else @(negedge ck_o);
      repeat (2) @(posedge clk_i);
      dqs_o <= 2'h3;
      repeat (4) @(posedge clk_i);
      dqs_o <= 2'h0;
    end
  endtask
  // a new beat at every strobe change while driven
  always @(posedge clk_i) begin
    if (dqs_oe_n_i[0] === 1'b0 && (prev_oe || dqs_i[0] !== prev_dqs)) begin
      if (prev_oe) rl_seen = rises - base;
      beats.push_back(dq_i);
    end
    prev_oe = dqs_oe_n_i[0] !== 1'b0;
    prev_dqs = dqs_i[0];
  end
endmodule

// file: sim/dtm_top_test.sv
`timescale 1ns/10ps
`include "dtm_defines.vh"
module dtm_top_test;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg reset_n_i = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'h0;
  reg [31:0] wb_dat_i = 32'h00000000;
  wire ck, cs_n, ras_n, cas_n, we_n, termination_control_pin, rtt_s, rtt_d, ard, apre, ack;
  wire [2:0] ba, aba;
  wire [12:0] addr;
  wire [1:0] dqs_w, dqs_d, dqs_oe;
  wire [15:0] dq, dq_oe;
  wire [9:0] acol;
  wire [31:0] wdat;
  integer bad_count = 0, cmp_count = 0, n_arr = 0, loc = 0, copy = 1, rl = 6, k, p;
  reg [31:0] seed = 32'h0000AD18;
  reg [31:0] q;
  reg [9:0] last_col;
  reg [2:0] last_ba;
  reg last_pre;
  dtm_ctrl_model M (.clk_i(clk_i), .dq_i(dq), .dqs_i(dqs_d), .dqs_oe_n_i(dqs_oe), .ck_o(ck), .cs_n_o(cs_n),
    .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr), .odt_o(termination_control_pin), .dqs_o(dqs_w));
  dtm_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ck_i(ck), .reset_n_i(reset_n_i), .cs_n_i(cs_n), .ras_n_i(ras_n),
    .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr), .odt_i(termination_control_pin), .dqs_i(dqs_w), .dq_o(dq),
    .dq_oe_n_o(dq_oe), .dqs_o(dqs_d), .dqs_oe_n_o(dqs_oe), .rtt_dqs_o(rtt_s), .rtt_dq_o(rtt_d),
    .array_rd_o(ard), .array_col_o(acol), .array_ba_o(aba), .auto_pre_o(apre), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wdat), .wb_ack_o(ack));
  // ----------------------------------------
  // clock, monitors and helpers
  // ----------------------------------------
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (ard === 1'b1) begin
    n_arr = n_arr + 1;
    last_col = acol;
    last_pre = apre;
    last_ba = aba;
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task complete_run;
    begin
      $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wb(input we, input [7:0] adr, input [31:0] dat);
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hF;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = wdat;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task prd(input chop, input nib, input integer nb, input integer lo);
    reg [7:0] pat;
    begin
      seed = xs(seed);
      M.beats.delete();
      M.cmd(`DTM_CMD_READ, seed[2:0], {chop, seed[11:3], nib, 2'b00});
      repeat (rl + 6) @(posedge ck);
      chk(M.beats.size(), nb);
      chk(M.rl_seen, rl);
      pat = (loc == 0) ? `DTM_CAL_PATTERN : `DTM_RSV_PATTERN;
      for (k = 0; k < nb; k = k + 1)
        chk(M.beats[k], {2{(copy ? {8{pat[lo + k]}} : {7'h00, pat[lo + k]})}});
    end
  endtask
  task nrd(input [12:0] a, input integer n_exp);
    begin
      M.cmd(`DTM_CMD_READ, 3'h5, a);
      repeat (2) @(posedge ck);
      chk(n_arr, n_exp);
      chk({last_ba, last_pre, last_col}, {3'h5, a[10], a[9:0]});
    end
  endtask
  initial begin
    #400000;
    bad_count = bad_count + 1;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `DTM_ADR_CTRL, 32'h0);
    chk(q, `DTM_CTRL_RESET);
    wb(1'b0, `DTM_ADR_LAT, 32'h0);
    chk(q, `DTM_LAT_RESET);
    seed = xs(seed);
    wb(1'b1, 8'h0C, seed);
    wb(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h0);
    p = 5 + seed[3:2];
    rl = p + seed[1:0];
    wb(1'b1, `DTM_ADR_LAT, {19'h0, p[4:0], 6'h00, seed[1:0]});
    wb(1'b0, `DTM_ADR_LAT, 32'h0);
    chk(q, {19'h0, p[4:0], 6'h00, seed[1:0]});
    // only reads and mode register sets are issued while pattern mode is on
    M.mode_set_command(`DTM_MR_THREE, 13'h0004);
    wb(1'b0, `DTM_ADR_STAT, 32'h0);
    chk(q, 32'h00000008);
    for (p = 0; p < 3; p = p + 1) begin
      M.mode_set_command(`DTM_MR_ZERO, p[12:0]);
      prd(1'b1, 1'b0, p == 2 ? 4 : 8, 0);
      prd(1'b0, p != 0, p == 0 ? 8 : 4, p == 0 ? 0 : 4);
    end
    chk(n_arr, 0);
    wb(1'b1, `DTM_ADR_CTRL, 32'h0);
    copy = 0;
    // reserved locations are read only to see their zero content, never to tune capture
    for (loc = 3; loc >= 0; loc = loc - 1) begin
      M.mode_set_command(`DTM_MR_THREE, {10'h000, 1'b1, loc[1:0]});
      prd(1'b0, 1'b0, 4, 0);
    end
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    seed = xs(seed);
    nrd(seed[12:0], 1);
    M.mode_set_command(`DTM_MR_THREE, 13'h0001);
    nrd(seed[12:0] | 13'h0400, 2);
    M.mode_set_command(`DTM_MR_ONE, 13'h0080);
    @(posedge clk_i);
    M.odt_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({rtt_s, rtt_d}, 2'b10);
    for (p = 0; p < 2; p = p + 1) begin
      wb(1'b1, `DTM_ADR_CTRL, {30'h0, p[0], 1'b1});
      M.lvl(1'b1);
      repeat (8) @(posedge clk_i);
      chk({dq_oe, dq}, {16'h0000, (p ? 16'h0101 : 16'hFFFF)});
      M.lvl(1'b0);
      repeat (8) @(posedge clk_i);
      chk(dq, 16'h0000);
    end
    M.mode_set_command(`DTM_MR_ONE, 13'h1080);
    chk(dq_oe, 16'hFFFF);
    M.mode_set_command(`DTM_MR_ONE, 13'h0080);
    chk(dq_oe, 16'h0000);
    @(posedge clk_i);
    M.odt_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk({rtt_s, rtt_d}, 2'b00);
    M.mode_set_command(`DTM_MR_ONE, 13'h0000);
    chk(dq_oe, 16'hFFFF);
    @(posedge clk_i);
    M.odt_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({rtt_s, rtt_d}, 2'b11);
    complete_run;
  end
endmodule
bind dtm_top dtm_props u_props (.clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .dq_o(dq_o),
  .dq_oe_n_o(dq_oe_n_o), .dqs_o(dqs_o), .dqs_oe_n_o(dqs_oe_n_o), .rtt_dqs_o(rtt_dqs_o), .rtt_dq_o(rtt_dq_o),
  .array_rd_o(array_rd_o), .auto_pre_o(auto_pre_o));
